// *** hw/fixed_point_mac_accumulator.v ***
// fixed-point multiply-accumulate datapath with two 80-bit accumulators and ahb-lite registers
//
// Contract
// - move in copies fixed field, ignores extension
// - move out writes fixed field, zero extension
// - x and y signedness chosen independently
// - integer or fractional operand format selectable
// - round-to-nearest modifier on written result
// - rounding only for fractional, never integer
// - multiply fixed fields, ignore extension fields
// - accumulate-add adds product to accumulator
// - accumulate-subtract subtracts product from accumulator
// - result returns only to source accumulator
// - data result bits 31-0 or 63-32
// - accumulator destination stores full 80 bits
// - underflow: fractional upper 48 flat, low nonzero
// - negative from result sign, invalid cleared
// - overflow when examined upper bits not flat
// - signed check: 33 fractional, 49 integer
// - unsigned check: 32 fractional, 48 integer
// - overflow sets sticky; other stickies untouched
//
// Chosen here: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "mac_defs.vh"

module fixed_point_mac_accumulator #(
   parameter DATA_REGS = 16
) (
   // clock and reset
   input  wire        clk,
   input  wire        reset,
   // ahb-lite slave
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [2:0]  hburst,
   input  wire [3:0]  hprot,
   input  wire        hmastlock,
   input  wire        hready,
   input  wire [31:0] hwdata,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   // interrupt
   output reg         irq
);

   localparam IDX_W = 4;
   localparam [11:0] DATA_BASE = `OFF_DATA_BASE;

   // bus phase tracking
   reg  [11:0] addr_r;
   reg         wrPend_r;
   reg         rdPend_r;
   // state
   reg  [31:0] cmd_r;
   reg  [3:0]  flags_r;
   reg  [3:0]  sticky_r;
   reg  [1:0]  irqStat_r;
   reg  [1:0]  irqMask_r;
   reg  [79:0] accF_r;
   reg  [79:0] accB_r;

   reg  [3:0]  flags_nxt;
   reg  [3:0]  sticky_nxt;
   reg  [1:0]  irqStat_nxt;
   reg  [79:0] accF_nxt;
   reg  [79:0] accB_nxt;
   reg  [31:0] rdData;

   wire [40*DATA_REGS-1:0] dataFlat;

   wire        addrTake = hsel & htrans[1] & hready;
   wire        busWr    = wrPend_r;
   wire        cmdWr    = busWr & (addr_r == `OFF_CMD);
   wire        dataHit  = (addr_r[11:7] == DATA_BASE[11:7]);
   wire [IDX_W-1:0] dataIdx = addr_r[6:3];

   // command decode
   wire [2:0]  op     = hwdata[`CMD_OP_MSB:`CMD_OP_LSB];
   wire        accSel = hwdata[`CMD_ACC_SEL];
   wire        toData = hwdata[`CMD_TO_DATA];
   wire        xSgn   = hwdata[`CMD_X_SIGNED];
   wire        ySgn   = hwdata[`CMD_Y_SIGNED];
   wire        frac   = hwdata[`CMD_FRAC];
   wire        rnd    = hwdata[`CMD_ROUND];
   wire [IDX_W-1:0] xIdx = hwdata[`CMD_X_LSB +: IDX_W];
   wire [IDX_W-1:0] yIdx = hwdata[`CMD_Y_LSB +: IDX_W];
   wire [IDX_W-1:0] nIdx = hwdata[`CMD_N_LSB +: IDX_W];

   wire isMac  = cmdWr & ((op == `OP_MAC_ADD) | (op == `OP_MAC_SUB));
   wire isIn   = cmdWr & (op == `OP_TO_ACC);
   wire isOut  = cmdWr & (op == `OP_FROM_ACC);

   // operands: only the fixed field [39:8] is used, extension [7:0] ignored
   wire [31:0] xFix = dataFlat[xIdx*40+8 +: 32];
   wire [31:0] yFix = dataFlat[yIdx*40+8 +: 32];
   wire signed [32:0] xOp = {xSgn & xFix[31], xFix};
   wire signed [32:0] yOp = {ySgn & yFix[31], yFix};
   wire signed [65:0] prodRaw = xOp * yOp;
   wire [79:0] prodExt = {{14{prodRaw[65]}}, prodRaw};
   // fractional product drops the duplicated sign bit
   wire [79:0] prod    = frac ? {prodExt[78:0], 1'b0} : prodExt;
   wire [79:0] accSrc  = accSel ? accB_r : accF_r;
   wire [79:0] sumRaw  = (op == `OP_MAC_SUB) ? accSrc - prod
                                             : accSrc + prod;
   wire        doRnd   = rnd & frac;
   wire [79:0] sumRnd  = sumRaw + `ROUND_HALF;
   wire [79:0] res     = doRnd ? {sumRnd[79:32], 32'h0000_0000} : sumRaw;
   wire        resSgn  = xSgn | ySgn;

   // overflow: examined upper bits must all be zero, or all one when signed
   reg         ovf;
   always @* begin
      if (frac & resSgn)
         ovf = ~((&res[79:`OVF_FS_LSB]) | ~(|res[79:`OVF_FS_LSB]));
      else if (frac)
         ovf = |res[79:`OVF_FU_LSB];
      else if (resSgn)
         ovf = ~((&res[79:`OVF_IS_LSB]) | ~(|res[79:`OVF_IS_LSB]));
      else
         ovf = |res[79:`OVF_IU_LSB];
   end

   wire hiZero = ~(|res[79:`UNF_HI_LSB]);
   wire hiOnes = &res[79:`UNF_HI_LSB];
   wire unf    = frac & (hiZero | (resSgn & hiOnes)) & (|res[31:0]);

   // result for a data register destination
   wire [31:0] resWord = frac ? res[63:32] : res[31:0];
   wire [31:0] accOutWord = accSel ? accB_r[31:0] : accF_r[31:0];

   // data register file, one entry per generate pass
   genvar g;
   generate
      for (g = 0; g < DATA_REGS; g = g + 1) begin : gen_data
         reg [39:0] ent_r;
         always @(posedge clk) begin
            if (reset)
               ent_r <= `RST_DATA;
            else if (isMac & toData & (nIdx == g))
               ent_r <= {resWord, 8'h00};
            else if (isOut & (nIdx == g))
               ent_r <= {accOutWord, 8'h00};
            else if (busWr & dataHit & (dataIdx == g) & ~addr_r[2])
               ent_r[39:8] <= hwdata;
            else if (busWr & dataHit & (dataIdx == g) & addr_r[2])
               ent_r[7:0] <= hwdata[7:0];
         end
         assign dataFlat[g*40 +: 40] = ent_r;
      end
   endgenerate

   // accumulators, flags, stickies, interrupt status
   always @* begin
      accF_nxt    = accF_r;
      accB_nxt    = accB_r;
      flags_nxt   = flags_r;
      sticky_nxt  = sticky_r;
      irqStat_nxt = irqStat_r;
      // software clears by writing ones; hardware events below win
      if (busWr & (addr_r == `OFF_STICKY))
         sticky_nxt = sticky_r & ~hwdata[3:0];
      if (busWr & (addr_r == `OFF_IRQ_STAT))
         irqStat_nxt = irqStat_r & ~hwdata[1:0];
      if (isIn) begin
         // fixed field lands in the low word, zero extended
         if (accSel)
            accB_nxt = {48'h0, xFix};
         else
            accF_nxt = {48'h0, xFix};
         flags_nxt = 4'h0;
      end
      if (isOut)
         flags_nxt = 4'h0;
      if (isMac) begin
         if (~toData) begin
            if (accSel)
               accB_nxt = res;
            else
               accF_nxt = res;
         end
         flags_nxt[`FLG_UNDER]   = unf;
         flags_nxt[`FLG_NEG]     = res[79];
         flags_nxt[`FLG_INVALID] = 1'b0;
         flags_nxt[`FLG_OVER]    = ovf;
         if (ovf) begin
            sticky_nxt[`STK_OVER] = 1'b1;
            irqStat_nxt[`IRQ_OVER] = 1'b1;
         end
      end
      if (isIn | isOut | isMac)
         irqStat_nxt[`IRQ_DONE] = 1'b1;
   end

   // read mux on the latched address
   always @* begin
      rdData = `RST_WORD;
      if (dataHit) begin
         if (addr_r[2])
            rdData = {24'h0, dataFlat[dataIdx*40 +: 8]};
         else
            rdData = dataFlat[dataIdx*40+8 +: 32];
      end else begin
         case (addr_r)
            `OFF_CMD:      rdData = cmd_r;
            `OFF_FLAGS:    rdData = {28'h0, flags_r};
            `OFF_STICKY:   rdData = {28'h0, sticky_r};
            `OFF_IRQ_STAT: rdData = {30'h0, irqStat_r};
            `OFF_IRQ_MASK: rdData = {30'h0, irqMask_r};
            `OFF_ACCF_0:   rdData = accF_r[31:0];
            `OFF_ACCF_1:   rdData = accF_r[63:32];
            `OFF_ACCF_2:   rdData = {16'h0, accF_r[79:64]};
            `OFF_ACCB_0:   rdData = accB_r[31:0];
            `OFF_ACCB_1:   rdData = accB_r[63:32];
            `OFF_ACCB_2:   rdData = {16'h0, accB_r[79:64]};
            default:       rdData = `RST_WORD;
         endcase
      end
   end

   // bus handshake: writes zero wait, reads one wait state
   always @(posedge clk) begin
      if (reset) begin
         addr_r    <= 12'h000;
         wrPend_r  <= 1'b0;
         rdPend_r  <= 1'b0;
         hreadyout <= 1'b1;
         hrdata    <= `RST_WORD;
         hresp     <= 1'b0;
      end else begin
         hresp    <= 1'b0;
         wrPend_r <= addrTake & hwrite;
         if (addrTake)
            addr_r <= {haddr[11:2], 2'b00};
         if (addrTake & ~hwrite) begin
            rdPend_r  <= 1'b1;
            hreadyout <= 1'b0;
         end else if (rdPend_r) begin
            rdPend_r  <= 1'b0;
            hreadyout <= 1'b1;
            hrdata    <= rdData;
         end
      end
   end

   // architectural state
   always @(posedge clk) begin
      if (reset) begin
         cmd_r     <= `RST_WORD;
         flags_r   <= 4'h0;
         sticky_r  <= 4'h0;
         irqStat_r <= 2'h0;
         irqMask_r <= 2'h0;
         accF_r    <= `RST_ACC;
         accB_r    <= `RST_ACC;
         irq       <= 1'b0;
      end else begin
         if (cmdWr)
            cmd_r <= hwdata;
         if (busWr & (addr_r == `OFF_IRQ_MASK))
            irqMask_r <= hwdata[1:0];
         flags_r   <= flags_nxt;
         sticky_r  <= sticky_nxt;
         irqStat_r <= irqStat_nxt;
         accF_r    <= accF_nxt;
         accB_r    <= accB_nxt;
         irq       <= |(irqStat_nxt & irqMask_r);
      end
   end

endmodule // fixed_point_mac_accumulator

// *** hw/mac_defs.vh ***
// offsets, command fields, flag positions and reset values of the mac accumulator
`ifndef MAC_DEFS_VH
`define MAC_DEFS_VH
// register byte offsets (low 12 address bits)
`define OFF_CMD       12'h000
`define OFF_FLAGS     12'h004
`define OFF_STICKY    12'h008
`define OFF_IRQ_STAT  12'h00c
`define OFF_IRQ_MASK  12'h010
`define OFF_ACCF_0    12'h020
`define OFF_ACCF_1    12'h024
`define OFF_ACCF_2    12'h028
`define OFF_ACCB_0    12'h030
`define OFF_ACCB_1    12'h034
`define OFF_ACCB_2    12'h038
`define OFF_DATA_BASE 12'h080
// command word fields
`define CMD_OP_MSB    2
`define CMD_OP_LSB    0
`define CMD_ACC_SEL   3
`define CMD_TO_DATA   4
`define CMD_X_SIGNED  5
`define CMD_Y_SIGNED  6
`define CMD_FRAC      7
`define CMD_ROUND     8
`define CMD_X_LSB     12
`define CMD_Y_LSB     16
`define CMD_N_LSB     20
// operation codes
`define OP_NOP        3'h0
`define OP_TO_ACC     3'h1
`define OP_FROM_ACC   3'h2
`define OP_MAC_ADD    3'h3
`define OP_MAC_SUB    3'h4
// arith flag bits
`define FLG_UNDER     0
`define FLG_NEG       1
`define FLG_INVALID   2
`define FLG_OVER      3
// sticky bits
`define STK_OVER      0
`define STK_INVALID   1
`define STK_OVER_ALT  2
`define STK_UNDER     3
// interrupt events
`define IRQ_DONE      0
`define IRQ_OVER      1
// result field bounds
`define OVF_FS_LSB    47
`define OVF_FU_LSB    48
`define OVF_IS_LSB    31
`define OVF_IU_LSB    32
`define UNF_HI_LSB    32
`define ROUND_HALF    80'h0000_0000_0000_8000_0000
// reset values
`define RST_WORD      32'h0000_0000
`define RST_ACC       80'h0
`define RST_DATA      40'h00_0000_0000
`endif

// *** bench/ahb_master.sv ***
// ahb-lite master model issuing single word transfers
`timescale 1ns/1ps
module ahb_master (
   // clock
   input  wire        clk,
   // bus answer
   input  wire        hready,
   input  wire [31:0] hrdata,
   // bus request
   output reg         hsel,
   output reg  [31:0] haddr,
   output reg  [1:0]  htrans,
   output reg         hwrite,
   output reg  [31:0] hwdata
);
   initial begin
      {hsel, haddr, htrans, hwrite, hwdata} = '0;
   end
   // waits for the rising edge at which hready is sampled high; data taken there
   task automatic wait_rdy(output logic [31:0] q);
      @(posedge clk);
      while (hready !== 1'b1)
         @(posedge clk);
      q = hrdata;
   endtask
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      @(posedge clk);
      hsel   <= 1'b1;
      haddr  <= {20'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      wait_rdy(q);
      htrans <= 2'h0;
      hsel   <= 1'b0;
      hwdata <= d;
      wait_rdy(q);
      // released data lines show a changed value
      hwdata <= ~d;
   endtask
endmodule // ahb_master

// *** bench/mac_asserts.sv ***
// bus-level checks of the mac accumulator
`timescale 1ns/1ps
module mac_asserts (
   // clock and reset
   input wire        clk,
   input wire        reset,
   // bus
   input wire        hsel,
   input wire [31:0] haddr,
   input wire [1:0]  htrans,
   input wire        hwrite,
   input wire        hready,
   input wire [31:0] hwdata,
   input wire [31:0] hrdata,
   input wire        hreadyout,
   input wire        hresp,
   input wire        irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   wire        take = hsel & htrans[1] & hready;
   reg  [11:0] rdAddr_r;
   reg  [2:0]  op_r;
   reg         rdWait_r, rdDone_r, cmdWr_r, frac_r;
   always @(posedge clk) begin
      rdWait_r <= !reset && take && !hwrite;
      rdDone_r <= !reset && rdWait_r;
      cmdWr_r  <= !reset && take && hwrite && haddr[11:2] == 10'h0;
      if (take && !hwrite)
         rdAddr_r <= haddr[11:0];
      if (reset)
         {frac_r, op_r} <= 4'h0;
      else if (cmdWr_r)
         {frac_r, op_r} <= {hwdata[7], hwdata[2:0]};
   end
   wire flagRd = rdDone_r && rdAddr_r[11:2] == 10'h1;
   sequence s_wait1;
      !hreadyout ##1 hreadyout;
   endsequence
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("error response seen");
   a_read_wait: assert property (take && !hwrite |=> s_wait1)
      else $error("read wait state wrong");
   a_write_nowait: assert property (take && hwrite |=> hreadyout)
      else $error("write stalled");
   a_invalid_clear: assert property (flagRd |-> !hrdata[2])
      else $error("invalid flag set");
   a_stickies_kept: assert property (rdDone_r && rdAddr_r[11:2] == 10'h2 |-> hrdata[3:1] == 3'h0)
      else $error("other sticky set");
   a_move_clears: assert property (flagRd && (op_r == 3'h1 || op_r == 3'h2) |-> hrdata[3:0] == 4'h0)
      else $error("move left flags");
   a_int_nounder: assert property (flagRd && op_r >= 3'h3 && !frac_r |-> !hrdata[0])
      else $error("integer underflow");
   a_unmapped_zero: assert property (rdDone_r && rdAddr_r[11:6] == 6'h1 |-> hrdata == 32'h0)
      else $error("unmapped read nonzero");
endmodule // mac_asserts
bind fixed_point_mac_accumulator mac_asserts u_chk (.clk(clk), .reset(reset), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq));

// *** bench/tb.sv ***
// self-checking bench of the mac accumulator
`timescale 1ns/1ps
`include "mac_defs.vh"
module tb;
   reg         clk, reset;
   wire        hsel, hwrite, hreadyout, hresp, irq;
   wire [31:0] haddr, hwdata, hrdata;
   wire [1:0]  htrans;
   int         n_mismatch = 0, checks = 0, cycles = 0;
   fixed_point_mac_accumulator DUT (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hburst(3'h0), .hprot(4'h3),
      .hmastlock(1'b0), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .irq(irq));
   ahb_master m (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic summarize();
      if (n_mismatch == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   always @(posedge clk) begin
      if (++cycles == 5000) begin
         n_mismatch++;
         summarize();
      end
   end
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic w(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      m.xfer(1'b1, a, d, q);
   endtask
   task automatic rc(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] q;
      m.xfer(1'b0, a, 32'h0, q);
      cmp(q, e);
   endtask
   function automatic logic [11:0] dr(input logic [3:0] i);
      return `OFF_DATA_BASE + {5'h0, i, 3'h0};
   endfunction
   // mods: b0 background, b1 to data, b2 x signed, b3 y signed, b4 fractional, b5 round
   function automatic logic [31:0] cmd(input logic [2:0] op, input logic [5:0] mods,
                                      input logic [3:0] x, y, n);
      return {8'h0, n, y, x, 3'h0, mods, op};
   endfunction
   task automatic t_mac();
      w(dr(4'h0), 32'hffff_fffe);
      w(dr(4'h0) + 12'h4, 32'h0000_00aa);
      w(dr(4'h1), 32'h0000_0003);
      w(`OFF_CMD, cmd(`OP_MAC_ADD, 6'h05, 4'h0, 4'h1, 4'h0));
      rc(`OFF_ACCB_0, 32'hffff_fffa);
      rc(`OFF_ACCB_2, 32'h0000_ffff);
      rc(`OFF_ACCF_0, 32'h0);
      rc(`OFF_FLAGS, 32'h2);
      w(`OFF_CMD, cmd(`OP_MAC_ADD, 6'h01, 4'h0, 4'h1, 4'h0));
      rc(`OFF_ACCB_1, 32'h2);
      rc(`OFF_FLAGS, 32'h8);
      rc(`OFF_STICKY, 32'h1);
      w(`OFF_CMD, cmd(`OP_MAC_SUB, 6'h01, 4'h0, 4'h1, 4'h0));
      rc(`OFF_ACCB_0, 32'hffff_fffa);
      rc(`OFF_FLAGS, 32'ha);
   endtask
   task automatic t_frac();
      w(dr(4'h3), 32'h4000_0000);
      w(dr(4'h4), 32'h0000_0001);
      w(dr(4'h5), 32'h0000_0002);
      w(`OFF_CMD, cmd(`OP_MAC_ADD, 6'h1e, 4'h3, 4'h4, 4'h6));
      rc(dr(4'h6), 32'h0);
      rc(`OFF_FLAGS, 32'h1);
      w(`OFF_CMD, cmd(`OP_MAC_ADD, 6'h3e, 4'h3, 4'h4, 4'h7));
      rc(dr(4'h7), 32'h1);
      rc(dr(4'h7) + 12'h4, 32'h0);
      rc(`OFF_FLAGS, 32'h0);
      w(`OFF_CMD, cmd(`OP_MAC_ADD, 6'h2e, 4'h3, 4'h5, 4'h8));
      rc(dr(4'h8), 32'h8000_0000);
      rc(`OFF_FLAGS, 32'h8);
   endtask
   task automatic t_move();
      w(`OFF_CMD, cmd(`OP_TO_ACC, 6'h00, 4'h0, 4'h0, 4'h0));
      rc(`OFF_ACCF_0, 32'hffff_fffe);
      rc(`OFF_ACCF_1, 32'h0);
      rc(`OFF_FLAGS, 32'h0);
      w(`OFF_CMD, cmd(`OP_FROM_ACC, 6'h00, 4'h0, 4'h0, 4'h2));
      rc(dr(4'h2), 32'hffff_fffe);
      rc(dr(4'h2) + 12'h4, 32'h0);
      rc(`OFF_STICKY, 32'h1);
   endtask
   task automatic t_irq();
      cmp({31'h0, irq}, 32'h0);
      rc(`OFF_IRQ_STAT, 32'h3);
      w(`OFF_IRQ_MASK, 32'h2);
      repeat (2) @(negedge clk);
      cmp({31'h0, irq}, 32'h1);
      w(`OFF_IRQ_STAT, 32'h3);
      repeat (2) @(negedge clk);
      cmp({31'h0, irq}, 32'h0);
      rc(`OFF_IRQ_STAT, 32'h0);
      w(`OFF_STICKY, 32'h1);
      rc(`OFF_STICKY, 32'h0);
   endtask
   task automatic t_unmapped();
      w(12'h040, 32'hffff_ffff);
      rc(12'h040, 32'h0);
      w(`OFF_ACCF_0, 32'h0000_1234);
      rc(`OFF_ACCF_0, 32'hffff_fffe);
   endtask
   initial begin
      reset = 1'b1;
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      t_mac();
      t_frac();
      t_move();
      t_irq();
      t_unmapped();
      summarize();
   end
endmodule // tb
